// ### core/msl_regs.svh
// register offsets, field positions, reset values and timing counts of the start limiter
`ifndef MSL_REGS_SVH
`define MSL_REGS_SVH

`define MSL_OFF_CTRL 8'h00
`define MSL_OFF_LIMIT 8'h04
`define MSL_OFF_HOLD 8'h08
`define MSL_OFF_STATUS 8'h0c
`define MSL_OFF_COUNT 8'h10
`define MSL_OFF_DISPLAY 8'h14
`define MSL_OFF_HOLDLEFT 8'h18

`define MSL_CTRL_EN_BIT 0
`define MSL_STAT_DET_BIT 0
`define MSL_STAT_OUT_BIT 1
`define MSL_STAT_PERMIT_BIT 2

`define MSL_RST_EN 1'b0
`define MSL_RST_LIMIT 4'h3
`define MSL_RST_HOLD 7'h3c

`define MSL_LIMIT_MIN 4'h1
`define MSL_LIMIT_MAX 4'ha
`define MSL_HOLD_MIN 7'h01
`define MSL_HOLD_MAX 7'h78

`define MSL_CLK_HZ 40000000
`define MSL_TICK_S 1
`define MSL_TICK_CYCLES (`MSL_CLK_HZ * `MSL_TICK_S)
`define MSL_CREDIT_H 1
`define MSL_CREDIT_TICKS (`MSL_CREDIT_H * 3600 / `MSL_TICK_S)
`define MSL_MIN_TICKS (60 / `MSL_TICK_S)

`endif

// ### core/msl_pkg.sv
// types shared by the start limiter files
package msl_pkg;
  typedef logic [19:0] msl_count_t;
  typedef logic [12:0] msl_hold_t;
  typedef logic [8:0] msl_disp_t;
  typedef logic [3:0] msl_limit_t;
  typedef logic [6:0] msl_holdset_t;
endpackage : msl_pkg

// ### core/msl_tick_gen.sv
// free-running prescaler giving a one-cycle tick per counter time unit
`timescale 1ns/1ps
`include "msl_regs.svh"
module msl_tick_gen #(
  parameter int unsigned CYCLES = `MSL_TICK_CYCLES
) (
  input wire logic clk,
  input wire logic rst_n,
  output logic tick
);
  logic [31:0] div_reg;
  wire div_wrap = (div_reg == 32'(CYCLES - 1));

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      div_reg <= 32'h0000_0000;
      tick <= 1'b0;
    end else begin
      div_reg <= div_wrap ? 32'h0000_0000 : div_reg + 32'h0000_0001;
      tick <= div_wrap;
    end
  end
endmodule : msl_tick_gen

// ### core/msl_start_limiter.sv
// motor start-frequency limiter with decaying start counter and AHB-Lite settings registers
`timescale 1ns/1ps
`include "msl_regs.svh"
module msl_start_limiter import msl_pkg::*; #(
  parameter int unsigned TICK_CYCLES = `MSL_TICK_CYCLES
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic start_detect,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  output logic start_limit_output,
  output logic start_limit_detect_flag,
  output msl_disp_t start_counter_display,
  output logic start_permit
);
  localparam msl_count_t CREDIT = 20'(`MSL_CREDIT_TICKS);
  localparam msl_count_t HALF_CREDIT = 20'(`MSL_CREDIT_TICKS / 2);
  localparam msl_count_t CNT_MAX = 20'hf_ffff;
  localparam msl_hold_t MIN_TICKS = 13'(`MSL_MIN_TICKS);

  logic tick;
  logic enable_reg;
  msl_limit_t limit_reg;
  msl_holdset_t hold_reg;
  msl_count_t cnt_reg;
  msl_count_t cnt_next;
  msl_hold_t hold_left_reg;
  msl_hold_t hold_left_next;
  logic flag_next;
  logic out_next;
  logic wr_pend_reg;
  logic [7:0] wr_addr_reg;

  msl_tick_gen #(
    .CYCLES(TICK_CYCLES)
  ) u_tick (
    .clk(clk),
    .rst_n(rst_n),
    .tick(tick)
  );

  // bus: zero wait state, read data prepared in the address phase
  wire addr_take = hsel & htrans[1] & hready;
  wire rd_take = addr_take & ~hwrite;
  wire wr_take = addr_take & hwrite & (hsize == 3'h2);
  wire wr_ctrl = wr_pend_reg & (wr_addr_reg == `MSL_OFF_CTRL);
  wire wr_limit = wr_pend_reg & (wr_addr_reg == `MSL_OFF_LIMIT);
  wire wr_hold = wr_pend_reg & (wr_addr_reg == `MSL_OFF_HOLD);
  wire [7:0] rd_addr = {haddr[7:2], 2'b00};
  wire addr_hi_zero = (haddr[31:8] == 24'h00_0000);

  // out-of-range settings are clamped, not rejected
  wire [3:0] limit_wr = hwdata[3:0];
  wire limit_hi = (hwdata[31:4] != 28'h000_0000) | (limit_wr > `MSL_LIMIT_MAX);
  wire msl_limit_t limit_clamped = limit_hi ? `MSL_LIMIT_MAX :
                                   (limit_wr < `MSL_LIMIT_MIN) ? `MSL_LIMIT_MIN : limit_wr;
  wire [6:0] hold_wr = hwdata[6:0];
  wire hold_hi = (hwdata[31:7] != 25'h000_0000) | (hold_wr > `MSL_HOLD_MAX);
  wire msl_holdset_t hold_clamped = hold_hi ? `MSL_HOLD_MAX :
                                    (hold_wr < `MSL_HOLD_MIN) ? `MSL_HOLD_MIN : hold_wr;

  // set and clear thresholds differ on purpose: a start sets once the counter
  // passes limit-1 hours (the last allowed start), while the flag, unless enable is cleared,
  // only clears once the rounded counter has fallen below the limit
  wire msl_count_t limit_ticks = 20'({16'h0000, limit_reg} * CREDIT);
  wire msl_count_t set_thresh = limit_ticks - CREDIT;
  wire msl_count_t thresh = limit_ticks - HALF_CREDIT;
  wire msl_count_t cnt_dec = (tick && cnt_reg != 20'h0_0000) ? cnt_reg - 20'h0_0001 : cnt_reg;
  wire add_room = (cnt_dec <= CNT_MAX - CREDIT);
  // saturate rather than wrap, so a storm of retries never looks like a quiet motor
  wire msl_count_t cnt_add = add_room ? cnt_dec + CREDIT : CNT_MAX;
  wire reach_limit = start_detect & enable_reg & (cnt_add > set_thresh);
  wire below_limit = (cnt_reg < thresh);
  wire msl_hold_t hold_load = 13'({6'h00, hold_reg} * MIN_TICKS);
  wire hold_expire = tick & (hold_left_reg == 13'h0001);
  wire [20:0] cnt_round = {1'b0, cnt_reg} + {1'b0, HALF_CREDIT};
  wire msl_disp_t disp_value = 9'(cnt_round / {1'b0, CREDIT});

  always_comb begin
    cnt_next = start_detect ? cnt_add : cnt_dec;
  end

  always_comb begin
    if (!enable_reg) begin
      out_next = 1'b0;
    end else if (start_detect && (reach_limit || start_limit_output)) begin
      out_next = 1'b1;
    end else if (hold_expire) begin
      out_next = 1'b0;
    end else begin
      out_next = start_limit_output;
    end
  end

  always_comb begin
    if (!enable_reg) begin
      flag_next = 1'b0;
    end else if (reach_limit) begin
      flag_next = 1'b1;
    end else if (below_limit && !start_limit_output) begin
      flag_next = 1'b0;
    end else begin
      flag_next = start_limit_detect_flag;
    end
  end

  // every start reloads the hold; harmless while the output is low
  always_comb begin
    if (start_detect) begin
      hold_left_next = hold_load;
    end else if (tick && hold_left_reg != 13'h0000) begin
      hold_left_next = hold_left_reg - 13'h0001;
    end else begin
      hold_left_next = hold_left_reg;
    end
  end

  wire [31:0] status_word = {29'h0000_0000, ~flag_next, start_limit_output, start_limit_detect_flag};
  wire [31:0] rd_data =
    !addr_hi_zero ? 32'h0000_0000 :
    (rd_addr == `MSL_OFF_CTRL) ? {31'h0000_0000, enable_reg} :
    (rd_addr == `MSL_OFF_LIMIT) ? {28'h000_0000, limit_reg} :
    (rd_addr == `MSL_OFF_HOLD) ? {25'h000_0000, hold_reg} :
    (rd_addr == `MSL_OFF_STATUS) ? {29'h0000_0000, status_word[2:0]} :
    (rd_addr == `MSL_OFF_COUNT) ? {12'h000, cnt_reg} :
    (rd_addr == `MSL_OFF_DISPLAY) ? {23'h00_0000, start_counter_display} :
    (rd_addr == `MSL_OFF_HOLDLEFT) ? {19'h0_0000, hold_left_reg} : 32'h0000_0000;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= 8'h00;
      hrdata <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      wr_pend_reg <= wr_take & addr_hi_zero;
      wr_addr_reg <= rd_addr;
      hrdata <= rd_take ? rd_data : 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      enable_reg <= `MSL_RST_EN;
      limit_reg <= `MSL_RST_LIMIT;
      hold_reg <= `MSL_RST_HOLD;
    end else begin
      if (wr_ctrl) enable_reg <= hwdata[`MSL_CTRL_EN_BIT];
      if (wr_limit) limit_reg <= limit_clamped;
      if (wr_hold) hold_reg <= hold_clamped;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_reg <= 20'h0_0000;
      hold_left_reg <= 13'h0000;
      start_limit_output <= 1'b0;
      start_limit_detect_flag <= 1'b0;
      start_counter_display <= 9'h000;
      start_permit <= 1'b1;
    end else begin
      cnt_reg <= cnt_next;
      hold_left_reg <= hold_left_next;
      start_limit_output <= out_next;
      start_limit_detect_flag <= flag_next;
      start_counter_display <= disp_value;
      start_permit <= ~flag_next;
    end
  end

  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);

  a_credit_add: assert property (
    (start_detect && !tick && cnt_reg <= CNT_MAX - CREDIT) |=> (cnt_reg == $past(cnt_reg) + CREDIT)
  ) else $error("start did not add one hour of credit");

  a_decay_step: assert property (
    (tick && !start_detect && cnt_reg != 20'h0_0000) |=> (cnt_reg == $past(cnt_reg) - 20'h0_0001)
  ) else $error("counter did not decay by one unit on tick");

  a_quiet_hold: assert property (
    (!tick && !start_detect) |=> $stable(cnt_reg)
  ) else $error("counter moved without tick or start");

  a_limit_set: assert property (
    reach_limit |=> (start_limit_output && start_limit_detect_flag && !start_permit)
  ) else $error("limit reached but flag or output not set");

  a_limit_keep: assert property (
    (enable_reg && start_limit_output && start_detect) |=> start_limit_output && hold_left_reg == $past(hold_load)
  ) else $error("retry while held did not keep output and reload hold");

  a_hold_drop: assert property (
    (enable_reg && start_limit_output && hold_expire && !start_detect) |=> !start_limit_output
  ) else $error("output not released at hold expiry");

  a_hold_stays: assert property (
    (start_limit_output && hold_left_reg > 13'h0001 && enable_reg) |=> start_limit_output
  ) else $error("output dropped before hold expiry");

  a_flag_clear: assert property (
    (start_limit_detect_flag && below_limit && !start_limit_output && !start_detect) |=>
      (!start_limit_detect_flag && start_permit)
  ) else $error("flag not cleared below the limit");

  a_display_round: assert property (
    ##1 ((32'(start_counter_display) * 32'(CREDIT) + 32'(HALF_CREDIT) > 32'($past(cnt_reg))) &&
         (32'(start_counter_display) * 32'(CREDIT) <= 32'($past(cnt_reg)) + 32'(HALF_CREDIT)))
  ) else $error("display is not the rounded counter");

  a_limit_range: assert property (
    (limit_reg >= `MSL_LIMIT_MIN) && (limit_reg <= `MSL_LIMIT_MAX)
  ) else $error("start limit setting out of range");

  a_hold_range: assert property (
    (hold_reg >= `MSL_HOLD_MIN) && (hold_reg <= `MSL_HOLD_MAX)
  ) else $error("hold time setting out of range");

  a_disabled_quiet: assert property (
    !enable_reg |=> (!start_limit_output && !start_limit_detect_flag)
  ) else $error("signal asserted while disabled");

  a_rise_on_start: assert property (
    $rose(start_limit_output) |-> $past(start_detect)
  ) else $error("output rose without a start");

  a_no_early_set: assert property (
    (start_detect && enable_reg && !start_limit_output && cnt_add <= set_thresh) |=> !start_limit_output
  ) else $error("output set below the start limit");

  a_flag_with_out: assert property (
    start_limit_output |-> start_limit_detect_flag
  ) else $error("output high while flag low");

  a_hold_reload: assert property (
    start_detect |=> (hold_left_reg == $past(hold_load))
  ) else $error("start did not reload the hold time");

  a_hold_count: assert property (
    (tick && !start_detect && hold_left_reg != 13'h0000) |=> (hold_left_reg == $past(hold_left_reg) - 13'h0001)
  ) else $error("hold time did not count down on tick");

  a_cnt_floor: assert property (
    (tick && !start_detect && cnt_reg == 20'h0_0000) |=> (cnt_reg == 20'h0_0000)
  ) else $error("counter decayed below zero");

  a_permit_flag: assert property (
    start_permit == !start_limit_detect_flag
  ) else $error("permit does not mirror the flag");

  a_flag_enabled: assert property (
    $rose(start_limit_detect_flag) |-> $past(enable_reg)
  ) else $error("flag rose while disabled");

  a_bus_okay: assert property (
    hreadyout && !hresp
  ) else $error("bus response not ready and okay");

  a_rdata_idle: assert property (
    !$past(rd_take) |-> (hrdata == 32'h0000_0000)
  ) else $error("read data not zero outside a read");

  a_limit_write: assert property (
    wr_limit |=> (limit_reg == $past(limit_clamped))
  ) else $error("limit write did not land");

  a_hold_write: assert property (
    wr_hold |=> (hold_reg == $past(hold_clamped))
  ) else $error("hold write did not land");

  a_ctrl_write: assert property (
    wr_ctrl |=> (enable_reg == $past(hwdata[`MSL_CTRL_EN_BIT]))
  ) else $error("enable write did not land");

  c_limit_reached: cover property (reach_limit ##1 start_limit_output);
  c_retry_held: cover property (start_limit_output && start_detect);
  c_hold_release: cover property (start_limit_output ##1 !start_limit_output && start_limit_detect_flag);
  c_flag_release: cover property (start_limit_detect_flag ##1 !start_limit_detect_flag);
  c_early_set: cover property (reach_limit && cnt_add < thresh);
endmodule : msl_start_limiter

// ### bench/msl_motor_model.sv
// motor starting circuit: a start command gives one detected start pulse
`timescale 1ns/1ps
module msl_motor_model (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic try_start,
  output logic start_detect
);
  // blocked accelerations are still tried, so sensing reports them too
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      start_detect <= 1'b0;
    end else begin
      start_detect <= try_start;
    end
  end
endmodule : msl_motor_model

// ### bench/tb_top.sv
// self-checking bench of the start limiter
`timescale 1ns/1ps
`include "msl_regs.svh"
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin n_fail++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, (a), (e)); end end
module tb_top;
  import msl_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic try_start = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0000_0000;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0000_0000;
  logic rd_dp = 1'b0;
  logic start_detect, hready, hresp, slo, sdf, perm;
  logic [31:0] hrdata;
  msl_disp_t disp;
  logic [31:0] rq[$];
  logic [31:0] exp_rd;
  int n_fail = 0;
  int cmp_count = 0;
  always #12.5 clk = ~clk;
  msl_start_limiter #(.TICK_CYCLES(2)) u_msl_start_limiter (.clk(clk), .rst_n(rst_n),
    .start_detect(start_detect), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hready),
    .hresp(hresp), .start_limit_output(slo), .start_limit_detect_flag(sdf),
    .start_counter_display(disp), .start_permit(perm));
  msl_motor_model u_msl_motor_model (.clk(clk), .rst_n(rst_n), .try_start(try_start),
    .start_detect(start_detect));
  // read data is judged against the oldest noted value
  always @(posedge clk) begin
    if (rd_dp && hready && rq.size() > 0) begin
      // popped once, so a mismatch print cannot eat the next note
      exp_rd = rq.pop_front();
      `CHK({hresp, hrdata}, {1'b0, exp_rd})
    end
  end
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr <= {24'h00_0000, a};
    do @(posedge clk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    rd_dp <= ~wr;
    do @(posedge clk); while (hready !== 1'b1);
    rd_dp <= 1'b0;
  endtask : bus
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    rq.push_back(e);
    bus(1'b0, a, 32'h0000_0000);
  endtask : rd
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    @(negedge clk);
  endtask : cyc
  task automatic start;
    @(posedge clk);
    try_start <= 1'b1;
    @(posedge clk);
    try_start <= 1'b0;
  endtask : start
  task automatic setup(input logic [31:0] en, input logic [31:0] lim);
    bus(1'b1, `MSL_OFF_CTRL, en);
    bus(1'b1, `MSL_OFF_LIMIT, lim);
    bus(1'b1, `MSL_OFF_HOLD, 32'h0000_0001);
  endtask : setup
  task automatic final_report;
    $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : final_report
  initial begin
    #1750000;
    n_fail++;
    final_report();
  end
  initial begin
    logic [31:0] l;
    logic [31:0] h;
    void'($urandom(94));
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    rd(`MSL_OFF_CTRL, 32'h0000_0000);
    rd(`MSL_OFF_LIMIT, 32'h0000_0003);
    rd(`MSL_OFF_HOLD, 32'h0000_003c);
    rd(`MSL_OFF_STATUS, 32'h0000_0004);
    rd(8'h1c, 32'h0000_0000);
    $display("reset test done");
    for (int i = 0; i < 6; i++) begin
      l = (i < 4) ? 32'(i * 5 - i / 3 * 4) : 32'($urandom % 16);
      h = (i < 4) ? 32'(i * 60 - i / 3 * 53) : 32'($urandom % 128);
      bus(1'b1, `MSL_OFF_LIMIT, l);
      rd(`MSL_OFF_LIMIT, (l == 0) ? 32'h1 : (l > 10) ? 32'ha : l);
      bus(1'b1, `MSL_OFF_HOLD, h);
      rd(`MSL_OFF_HOLD, (h == 0) ? 32'h1 : (h > 120) ? 32'h78 : h);
    end
    $display("settings test done");
    setup(32'h0000_0000, 32'h0000_0001);
    start();
    cyc(2);
    `CHK({slo, sdf, perm}, 3'b001)
    `CHK(disp, 9'h001)
    cyc(7300);
    `CHK(disp, 9'h000)
    $display("disabled test done");
    setup(32'h0000_0001, 32'h0000_0003);
    // starts 20 min apart: the third lands near 2.33 h, below the rounded limit
    start();
    cyc(2400);
    start();
    cyc(2);
    `CHK({slo, sdf, disp}, 11'h002)
    cyc(2400);
    start();
    cyc(2);
    `CHK({slo, sdf, perm, disp}, 12'hc02)
    bus(1'b1, `MSL_OFF_CTRL, 32'h0000_0000);
    cyc(2);
    `CHK({slo, sdf}, 2'b00)
    cyc(21700);
    `CHK(disp, 9'h000)
    $display("limit test done");
    setup(32'h0000_0001, 32'h0000_0001);
    start();
    cyc(2);
    `CHK({slo, sdf, perm, disp}, 12'hc01)
    rd(`MSL_OFF_STATUS, 32'h0000_0003);
    cyc(90);
    start();
    cyc(2);
    `CHK(disp, 9'h002)
    cyc(100);
    `CHK(slo, 1'b1)
    cyc(30);
    `CHK({slo, sdf}, 2'b01)
    cyc(10518);
    `CHK({sdf, disp}, 10'h201)
    cyc(110);
    `CHK({sdf, perm, disp}, 11'h200)
    $display("hold test done");
    final_report();
  end
endmodule : tb_top
